// [verilog/cmpd_defines.svh]
// register offsets, field positions, reset values and timing counts of the comparator channel
`ifndef CMPD_DEFINES_SVH
`define CMPD_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CMPD_OFF_CONTROL 4'h0
`define CMPD_OFF_THRESHOLD 4'h4
`define CMPD_OFF_IRQ_STATUS 4'h8
`define CMPD_OFF_IRQ_MASK 4'hC

// ---------------------------------------------------------------
// control, threshold and interrupt register fields
// ---------------------------------------------------------------
`define CMPD_BIT_ENABLE 15
`define CMPD_BIT_IDLE_STOP 13
`define CMPD_BIT_REF_OUT 8
`define CMPD_SEL_HI 7
`define CMPD_SEL_LO 6
`define CMPD_BIT_EXTERNAL_REFERENCE_SELECT 5
`define CMPD_BIT_STATE 3
`define CMPD_BIT_INVERT 1
`define CMPD_BIT_RANGE 0
`define CMPD_CODE_HI 9
`define CMPD_CODE_LO 0
`define CMPD_BIT_EVENT 0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CMPD_RST_BIT 1'b0
`define CMPD_RST_SEL 2'h0
`define CMPD_RST_CODE 10'h000
`define CMPD_RST_WORD 32'h0000_0000

// ---------------------------------------------------------------
// timing: one instruction cycle and the glitch window
// ---------------------------------------------------------------
`define CMPD_CLK_PERIOD_NS 8
`define CMPD_TCY_NS 25
`define CMPD_FILTER_NS (2 * `CMPD_TCY_NS)
// least time rounds up
`define CMPD_FILTER_CYCLES ((`CMPD_FILTER_NS + `CMPD_CLK_PERIOD_NS - 1) / `CMPD_CLK_PERIOD_NS)
// pulse length rounds down, one cycle at least
`define CMPD_PULSE_CYCLES ((`CMPD_TCY_NS / `CMPD_CLK_PERIOD_NS) < 1 ? 1 : (`CMPD_TCY_NS / `CMPD_CLK_PERIOD_NS))

`endif

// [verilog/cmpd_pkg.sv]
// shared types of the comparator channel
`default_nettype none
package cmpd_pkg;
   // input multiplexer selection
   typedef enum logic [1:0] {
      CMPD_IN_A = 2'h0,
      CMPD_IN_B = 2'h1,
      CMPD_IN_C = 2'h2,
      CMPD_IN_D = 2'h3
   } cmpd_insel_e;

   // event pulse generator states
   typedef enum logic {
      CMPD_PS_IDLE,
      CMPD_PS_HIGH
   } cmpd_pulse_e;
endpackage
`default_nettype wire

// [verilog/cmpd_glitch_filter.sv]
// synchroniser, polarity and glitch filter for the raw comparator output
`timescale 1ns/1ns
`default_nettype none
`include "cmpd_defines.svh"
module cmpd_glitch_filter #(
   parameter int FILTER_CYCLES = `CMPD_FILTER_CYCLES,
   parameter int CNT_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw_in,
   input wire logic invert,
   input wire logic run,
   input wire logic bypass,
   output logic filt_q
);
   logic sync1_q;
   logic sync2_q;
   logic polar;
   logic filt_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(FILTER_CYCLES - 1);

   // -------------------------------------------------------------
   // synchroniser
   // -------------------------------------------------------------
   // two flop synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= `CMPD_RST_BIT;
         sync2_q <= `CMPD_RST_BIT;
      end
      else
      begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // -------------------------------------------------------------
   // filter
   // -------------------------------------------------------------
   // polarity before use
   assign polar = sync2_q ^ invert;

   // new level must persist the whole window before it is accepted
   always_comb
   begin
      cnt_d = '0;
      filt_d = filt_q;
      if (!run)
      begin
         filt_d = `CMPD_RST_BIT;
      end
      else if (bypass)
      begin
         filt_d = polar;
      end
      else if (polar != filt_q)
      begin
         if (cnt_q >= LAST)
            filt_d = polar;
         else
            cnt_d = cnt_q + CNT_W'(1);
      end
   end

   // registers of the filter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
         filt_q <= `CMPD_RST_BIT;
      end
      else
      begin
         cnt_q <= cnt_d;
         filt_q <= filt_d;
      end
   end
endmodule
`default_nettype wire

// [verilog/cmpd_channel.sv]
// comparator channel control: apb registers, idle gating, event pulse and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "cmpd_defines.svh"
module cmpd_channel #(
   parameter int PULSE_CYCLES = `CMPD_PULSE_CYCLES,
   parameter int PCNT_W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comparator_raw,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic group_idle_stop,
   output logic idle_stop,
   output logic comparator_power_enable,
   output logic ref_out_enable,
   output cmpd_pkg::cmpd_insel_e input_select,
   output logic external_reference_select,
   output logic range_high_select,
   output logic [9:0] dac_level_code,
   output logic comparator_state,
   output logic wake_async,
   output logic event_pulse,
   output logic irq
);
   // control and threshold state
   logic enable_q;
   logic enable_d;
   logic idle_stop_q;
   logic idle_stop_d;
   logic ref_out_q;
   logic ref_out_d;
   cmpd_pkg::cmpd_insel_e sel_q;
   cmpd_pkg::cmpd_insel_e sel_d;
   logic external_reference_select_q;
   logic external_reference_select_d;
   logic invert_q;
   logic invert_d;
   logic range_q;
   logic range_d;
   logic [9:0] code_q;
   logic [9:0] code_d;
   logic mask_q;
   logic mask_d;
   logic status_q;
   logic status_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   // pulse generator
   cmpd_pkg::cmpd_pulse_e pstate_q;
   cmpd_pkg::cmpd_pulse_e pstate_d;
   logic [PCNT_W-1:0] pcnt_q;
   logic [PCNT_W-1:0] pcnt_d;
   logic filt;
   logic filt_prev_q;
   logic run;
   logic low_power;
   logic rise;
   logic setup;
   logic wr;
   logic rd;
   logic mapped;

   // decode of one word offset, used for reads and writes
   function automatic logic hit(input logic [11:0] addr, input logic [3:0] off);
      hit = (addr[11:4] == 8'h00) && (addr[3:0] == off);
   endfunction

   // -------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------
   // zero wait states: read data is captured in the setup cycle
   assign mapped = hit(paddr, `CMPD_OFF_CONTROL) || hit(paddr, `CMPD_OFF_THRESHOLD) ||
                   hit(paddr, `CMPD_OFF_IRQ_STATUS) || hit(paddr, `CMPD_OFF_IRQ_MASK);
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && mapped;
   assign rd = psel && penable && !pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_q;

   // readback word; unimplemented bits stay zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (setup)
      begin
         rdata_d = `CMPD_RST_WORD;
         if (hit(paddr, `CMPD_OFF_CONTROL))
         begin
            rdata_d[`CMPD_BIT_ENABLE] = enable_q;
            rdata_d[`CMPD_BIT_IDLE_STOP] = idle_stop_q;
            rdata_d[`CMPD_BIT_REF_OUT] = ref_out_q;
            rdata_d[`CMPD_SEL_HI:`CMPD_SEL_LO] = sel_q;
            rdata_d[`CMPD_BIT_EXTERNAL_REFERENCE_SELECT] = external_reference_select_q;
            rdata_d[`CMPD_BIT_STATE] = filt;
            rdata_d[`CMPD_BIT_INVERT] = invert_q;
            rdata_d[`CMPD_BIT_RANGE] = range_q;
         end
         else if (hit(paddr, `CMPD_OFF_THRESHOLD))
            rdata_d[`CMPD_CODE_HI:`CMPD_CODE_LO] = code_q;
         else if (hit(paddr, `CMPD_OFF_IRQ_STATUS))
            rdata_d[`CMPD_BIT_EVENT] = status_q;
         else if (hit(paddr, `CMPD_OFF_IRQ_MASK))
            rdata_d[`CMPD_BIT_EVENT] = mask_q;
      end
   end

   // -------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------
   // only implemented bits are stored, so reserved writes vanish
   always_comb
   begin
      enable_d = enable_q;
      idle_stop_d = idle_stop_q;
      ref_out_d = ref_out_q;
      sel_d = sel_q;
      external_reference_select_d = external_reference_select_q;
      invert_d = invert_q;
      range_d = range_q;
      code_d = code_q;
      mask_d = mask_q;
      if (wr && hit(paddr, `CMPD_OFF_CONTROL))
      begin
         if (pstrb[1])
         begin
            enable_d = pwdata[`CMPD_BIT_ENABLE];
            idle_stop_d = pwdata[`CMPD_BIT_IDLE_STOP];
            ref_out_d = pwdata[`CMPD_BIT_REF_OUT];
         end
         if (pstrb[0])
         begin
            sel_d = cmpd_pkg::cmpd_insel_e'(pwdata[`CMPD_SEL_HI:`CMPD_SEL_LO]);
            external_reference_select_d = pwdata[`CMPD_BIT_EXTERNAL_REFERENCE_SELECT];
            invert_d = pwdata[`CMPD_BIT_INVERT];
            range_d = pwdata[`CMPD_BIT_RANGE];
         end
      end
      if (wr && hit(paddr, `CMPD_OFF_THRESHOLD))
      begin
         if (pstrb[0])
            code_d[7:0] = pwdata[7:0];
         if (pstrb[1])
            code_d[`CMPD_CODE_HI:8] = pwdata[`CMPD_CODE_HI:8];
      end
      if (wr && hit(paddr, `CMPD_OFF_IRQ_MASK) && pstrb[0])
         mask_d = pwdata[`CMPD_BIT_EVENT];
   end

   // sticky event flag: a new event beats the clear-on-read
   always_comb
   begin
      status_d = status_q;
      if (rd && hit(paddr, `CMPD_OFF_IRQ_STATUS))
         status_d = 1'b0;
      if (rise)
         status_d = 1'b1;
   end

   // registers of the bus side
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_q <= `CMPD_RST_BIT;
         idle_stop_q <= `CMPD_RST_BIT;
         ref_out_q <= `CMPD_RST_BIT;
         sel_q <= cmpd_pkg::CMPD_IN_A;
         external_reference_select_q <= `CMPD_RST_BIT;
         invert_q <= `CMPD_RST_BIT;
         range_q <= `CMPD_RST_BIT;
         code_q <= `CMPD_RST_CODE;
         mask_q <= `CMPD_RST_BIT;
         status_q <= `CMPD_RST_BIT;
         rdata_q <= `CMPD_RST_WORD;
      end
      else
      begin
         enable_q <= enable_d;
         idle_stop_q <= idle_stop_d;
         ref_out_q <= ref_out_d;
         sel_q <= sel_d;
         external_reference_select_q <= external_reference_select_d;
         invert_q <= invert_d;
         range_q <= range_d;
         code_q <= code_d;
         mask_q <= mask_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
      end
   end

   // -------------------------------------------------------------
   // analog side controls
   // -------------------------------------------------------------
   // local or group idle stop
   assign run = enable_q && !(idle_mode && (idle_stop_q || group_idle_stop));
   assign low_power = idle_mode || sleep_mode;
   assign idle_stop = idle_stop_q;
   assign comparator_power_enable = run;
   assign ref_out_enable = ref_out_q;
   assign input_select = sel_q;
   assign external_reference_select = external_reference_select_q;
   assign range_high_select = range_q;
   assign dac_level_code = code_q;
   assign comparator_state = filt;
   // unclocked wake path, only usable while the clock may be stopped
   assign wake_async = run && low_power && (comparator_raw ^ invert_q);

   cmpd_glitch_filter #(
      .FILTER_CYCLES(`CMPD_FILTER_CYCLES),
      .CNT_W(4)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(comparator_raw),
      .invert(invert_q),
      .run(run),
      .bypass(low_power),
      .filt_q(filt)
   );

   // -------------------------------------------------------------
   // event pulse and interrupt
   // -------------------------------------------------------------
   assign rise = filt && !filt_prev_q;

   always_comb
   begin
      pstate_d = pstate_q;
      pcnt_d = pcnt_q;
      unique case (pstate_q)
         cmpd_pkg::CMPD_PS_IDLE:
         begin
            if (rise)
            begin
               pstate_d = cmpd_pkg::CMPD_PS_HIGH;
               pcnt_d = PCNT_W'(PULSE_CYCLES - 1);
            end
         end
         cmpd_pkg::CMPD_PS_HIGH:
         begin
            if (pcnt_q == '0)
               pstate_d = cmpd_pkg::CMPD_PS_IDLE;
            else
               pcnt_d = pcnt_q - PCNT_W'(1);
         end
      endcase
   end

   // pulse registers; an edge during a running pulse is merged into it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pstate_q <= cmpd_pkg::CMPD_PS_IDLE;
         pcnt_q <= '0;
         filt_prev_q <= `CMPD_RST_BIT;
      end
      else
      begin
         pstate_q <= pstate_d;
         pcnt_q <= pcnt_d;
         filt_prev_q <= filt;
      end
   end

   assign event_pulse = (pstate_q == cmpd_pkg::CMPD_PS_HIGH);
   assign irq = status_q && mask_q;
endmodule
`default_nettype wire

// [verif/cmpd_analog_model.sv]
// behavioural analog front end: input mux, reference dac and comparator
`timescale 1ns/1ns
`default_nettype none
module cmpd_analog_model (
   input wire logic pclk,
   input wire logic power_on,
   input wire logic [1:0] sel,
   input wire logic ext_sel,
   input wire logic range_hi,
   input wire logic [9:0] code,
   output logic raw
);
   // input levels a..d and external reference, in millivolts
   int mv [5] = '{100, 200, 400, 800, 1500};
   int ref_mv;
   int dac_mv;
   logic flip = 1'b0;
   // a powered-down comparator gives no valid level, so it wanders
   always @(posedge pclk) flip <= ~flip;
   always_comb ref_mv = ext_sel ? mv[4] : (range_hi ? 1650 : 1200);
   always_comb dac_mv = int'(code) * ref_mv / 1024;
   assign raw = power_on ? (mv[sel] > dac_mv) : flip;
endmodule
`default_nettype wire

// [verif/cmpd_channel_chk.sv]
// port assertions of the comparator channel
`timescale 1ns/1ns
`default_nettype none
module cmpd_channel_chk #(
   parameter int PULSE_CYCLES = 3,
   parameter int PCNT_W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic comparator_raw,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic group_idle_stop,
   input wire logic idle_stop,
   input wire logic comparator_power_enable,
   input wire logic ref_out_enable,
   input wire cmpd_pkg::cmpd_insel_e input_select,
   input wire logic external_reference_select,
   input wire logic range_high_select,
   input wire logic [9:0] dac_level_code,
   input wire logic comparator_state,
   input wire logic wake_async,
   input wire logic event_pulse,
   input wire logic irq
);
   logic raw_q, raw_d;
   logic [3:0] run_q, run_d, age_q, age_d, plen_q, plen_d;
   logic [31:0] pw_q, pw_d;
   logic acc, wr_ok, normal;
   assign acc = psel && penable;
   assign wr_ok = acc && pwrite && pstrb == 4'hF;
   assign normal = comparator_power_enable && !idle_mode && !sleep_mode;
   // raw run length, age of the last run long enough to pass the filter
   always_comb
   begin
      raw_d = comparator_raw;
      run_d = (comparator_raw != raw_q) ? 4'h0 : run_q + {3'h0, run_q != 4'hF};
      age_d = (run_q >= 4'h6) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      plen_d = event_pulse ? plen_q + 4'h1 : 4'h0;
      pw_d = pwdata;
   end
   // age starts large: no state change is excused before a long run
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         raw_q <= 1'b0;
         run_q <= 4'h0;
         age_q <= 4'hF;
         plen_q <= 4'h0;
         pw_q <= 32'h0000_0000;
      end
      else
      begin
         raw_q <= raw_d;
         run_q <= run_d;
         age_q <= age_d;
         plen_q <= plen_d;
         pw_q <= pw_d;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_IDLE_OFF: assert property (idle_mode && (idle_stop || group_idle_stop) |-> !comparator_power_enable)
      else $error("channel powered while idle stop applies");
   AST_OFF_LOW: assert property (!comparator_power_enable ##1 !comparator_power_enable |-> !comparator_state)
      else $error("state high while powered down");
   AST_FILTER: assert property ($changed(comparator_state) && normal && $past(normal) |-> age_q <= 4'h3)
      else $error("state changed without a long enough input run");
   AST_BYPASS: assert property ((sleep_mode && comparator_power_enable && $stable(wake_async))[*4]
      |-> comparator_state == wake_async)
      else $error("state not following input in sleep");
   AST_WAKE_GATE: assert property (!comparator_power_enable || !(idle_mode || sleep_mode) |-> !wake_async)
      else $error("wake path active outside low power");
   AST_PULSE_START: assert property ($rose(comparator_state) && !event_pulse |=> $rose(event_pulse))
      else $error("no event pulse after state rise");
   AST_PULSE_LEN: assert property ($fell(event_pulse) |-> int'(plen_q) == PULSE_CYCLES)
      else $error("event pulse of wrong length");
   AST_IRQ_CLEAR: assert property (acc && !pwrite && paddr == 12'h008 && !$rose(comparator_state) |=> !irq)
      else $error("interrupt stays after status read");
   AST_CTRL_WRITE: assert property (wr_ok && paddr == 12'h000 |=> idle_stop == pw_q[13] && ref_out_enable == pw_q[8]
      && input_select == pw_q[7:6] && external_reference_select == pw_q[5] && range_high_select == pw_q[0])
      else $error("control outputs differ from written word");
   AST_CODE_WRITE: assert property (wr_ok && paddr == 12'h004 |=> dac_level_code == pw_q[9:0])
      else $error("dac code differs from written word");
   AST_UNMAPPED: assert property (acc && paddr[11:4] != 8'h00 |-> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_CTRL_READ: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31:16] == 16'h0000
      && {prdata[14], prdata[12:9], prdata[4], prdata[2]} == 7'h00 && prdata[8] == ref_out_enable)
      else $error("control read shows reserved bits or wrong enable");
endmodule
bind cmpd_channel cmpd_channel_chk #(.PULSE_CYCLES(PULSE_CYCLES), .PCNT_W(PCNT_W)) i_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .comparator_raw, .idle_mode, .sleep_mode,
   .group_idle_stop, .idle_stop, .comparator_power_enable, .ref_out_enable, .input_select, .external_reference_select,
   .range_high_select, .dac_level_code, .comparator_state, .wake_async, .event_pulse, .irq);
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the comparator channel
`timescale 1ns/1ns
`default_nettype none
`include "cmpd_defines.svh"
module tb;
   localparam logic [11:0] A_CTL = 12'(`CMPD_OFF_CONTROL);
   localparam logic [11:0] A_THR = 12'(`CMPD_OFF_THRESHOLD);
   localparam logic [11:0] A_ST = 12'(`CMPD_OFF_IRQ_STATUS);
   localparam logic [11:0] A_MSK = 12'(`CMPD_OFF_IRQ_MASK);
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, comparator_raw, idle_stop, comparator_power_enable, ref_out_enable, irq;
   logic external_reference_select, range_high_select, comparator_state, wake_async, event_pulse;
   logic idle_mode = 1'b0, sleep_mode = 1'b0, group_idle_stop = 1'b0;
   cmpd_pkg::cmpd_insel_e input_select;
   logic [9:0] dac_level_code;
   int n_errors = 0, checks = 0, cyc = 0, np;
   // [27:16] code, [15:0] control word with expected state in bit 3
   logic [31:0] tab [12] = '{32'h0100_8000, 32'h0100_8040, 32'h0100_8088, 32'h0100_80C8, 32'h0100_8081,
      32'h0100_80A8, 32'h0100_80A9, 32'h0100_8082, 32'h0100_800A, 32'h0100_0080, 32'h0000_8008, 32'h03FF_80C1};
   cmpd_channel i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .comparator_raw, .idle_mode, .sleep_mode, .group_idle_stop, .idle_stop, .comparator_power_enable,
      .ref_out_enable, .input_select, .external_reference_select, .range_high_select, .dac_level_code,
      .comparator_state, .wake_async, .event_pulse, .irq);
   cmpd_analog_model i_ana (.pclk, .power_on(comparator_power_enable), .sel(input_select),
      .ext_sel(external_reference_select), .range_hi(range_high_select), .code(dac_level_code), .raw(comparator_raw));
   always #4 pclk = ~pclk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rv, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      tick(20);
      presetn <= 1'b1;
      for (int a = 0; a < 16; a += 4)
         rd(12'(a), 32'h0000_0000);
      wr(A_CTL, 32'hFFFF_7FFF);
      rd(A_CTL, 32'h0000_21E3);
      chk({idle_stop, ref_out_enable, input_select, external_reference_select, range_high_select,
         comparator_power_enable}, 32'h0000_007E);
      wr(A_THR, 32'hFFFF_FFFF);
      rd(A_THR, 32'h0000_03FF);
      // byte strobes: only the low lane is written, upper code bits keep their value
      pstrb <= 4'h1;
      wr(A_THR, 32'h0000_0000);
      pstrb <= 4'hF;
      rd(A_THR, 32'h0000_0300);
      // every input, reference and polarity choice against the dac
      foreach (tab[i])
      begin
         wr(A_THR, {20'h00000, tab[i][27:16]});
         wr(A_CTL, {16'h0000, tab[i][15:0]});
         tick(16);
         chk(comparator_state, tab[i][3]);
         chk(dac_level_code, tab[i][25:16]);
         rd(A_CTL, {16'h0000, tab[i][15:0]});
      end
      wr(A_THR, 32'h0000_0100);
      wr(A_CTL, 32'h0000_8000);
      tick(16);
      apb(1'b0, A_ST, 32'h0000_0000);
      // six cycles is one short of the filter window
      i_ana.mv[0] <= 800;
      tick(6);
      i_ana.mv[0] <= 100;
      tick(16);
      chk(comparator_state, 1'b0);
      rd(A_ST, 32'h0000_0000);
      i_ana.mv[0] <= 800;
      np = 0;
      repeat (24)
      begin
         @(posedge pclk);
         np += int'(event_pulse === 1'b1);
      end
      chk(np, 3);
      chk({comparator_state, irq}, 2'b10);
      rd(A_ST, 32'h0000_0001);
      rd(A_ST, 32'h0000_0000);
      wr(A_MSK, 32'h0000_0001);
      rd(A_MSK, 32'h0000_0001);
      i_ana.mv[0] <= 100;
      tick(16);
      i_ana.mv[0] <= 800;
      tick(16);
      chk(irq, 1'b1);
      rd(A_ST, 32'h0000_0001);
      tick(1);
      chk(irq, 1'b0);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(rv, 32'h0000_0000);
      chk(ev, 1'b1);
      wr(A_CTL, 32'h0000_A000);
      idle_mode <= 1'b1;
      tick(2);
      chk(comparator_power_enable, 1'b0);
      wr(A_CTL, 32'h0000_8000);
      group_idle_stop <= 1'b1;
      tick(2);
      chk(comparator_power_enable, 1'b0);
      group_idle_stop <= 1'b0;
      tick(2);
      chk(comparator_power_enable, 1'b1);
      idle_mode <= 1'b0;
      sleep_mode <= 1'b1;
      tick(4);
      i_ana.mv[0] <= 100;
      tick(4);
      chk({comparator_state, wake_async}, 2'b00);
      i_ana.mv[0] <= 800;
      tick(4);
      chk({comparator_state, wake_async}, 2'b11);
      wrap_up();
   end
endmodule
`default_nettype wire
